// ---- udec_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Bus timing and control output checks.
module udec_asserts (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire udec_pkg::udec_evt_s evt,
  input wire udec_pkg::udec_phy_s phy,
  input wire udec_pkg::udec_ctl_s ctl,
  input wire udec_pkg::udec_ep8_t ep_ctrl,
  input wire logic usb_irq
);
  import udec_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire logic take = hsel && htrans[1] && hready;
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout) else $error("bad read wait");
  a_write_nowait: assert property (take && hwrite |=> hreadyout) else $error("write stalled");
  a_resp_okay: assert property (!hresp) else $error("error response");
  a_irq_dma: assert property (usb_irq |-> ctl.dma_en || $past(ctl.dma_en)) else $error("irq with dma off");
  a_pullup_func: assert property (phy.pu_dp || phy.pu_dm |-> phy.func_en) else $error("pull-up, no function");
  a_pullup_one: assert property (!(phy.pu_dp && phy.pu_dm)) else $error("both pull-ups on");
  a_pullup_prio: assert property (phy.pu_dp |-> !phy.pd_dp) else $error("pull-down beside pull-up");
  a_engine_hold: assert property (ctl.eng_rst [*3] |-> ep_ctrl == '0 && !phy.port_en) else $error("engine not held");
  a_clear_quiet: assert property (ctl.fifo_clr [*4] |-> !usb_irq) else $error("irq during clear");
  a_event_irq: assert property (evt.bus_rst && ctl.dma_en && !ctl.eng_rst && !ctl.fifo_clr && $stable(ctl)
    |-> ##[1:3] usb_irq) else $error("event gave no irq");
endmodule : udec_asserts
`default_nettype wire

// ---- udec_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Host side: bus events and finished transactions, one at a time.
module udec_host_model (
  input wire logic core_clk,
  output var udec_pkg::udec_evt_s evt
);
  import udec_pkg::*;
  initial evt = '0;
  // Kind 0 bus reset, 1 suspend, 2 transfer done, 3 FIFO overflow.
  task automatic pulse(input int k, input logic [3:0] e, input logic [1:0] t, input logic g, input logic [7:0] n);
    @(posedge core_clk);
    evt <= {k == 0, k == 1, k == 3, k == 2, 1'b0, e, t, g, n};
    @(posedge core_clk);
    evt <= {4'h0, ~evt[15:0]};
    repeat (2) @(posedge core_clk);
  endtask : pulse
endmodule : udec_host_model
`default_nettype wire

// ---- udec_pkg.sv ----
// What this block does
// - Speed bit picks 12Mbps or 1.5Mbps.
// - Pending transfer flag plus pause bit forces NAK.
// - Engine reset bit holds engine, resets to one.
// - Clear-all bit empties flags and FIFO.
// - DMA enable gates buffer DMA and interrupts.
// - System field sets function and internal pull-up.
// - Internal pull-up overrides pull-down, needs function enabled.
// - Seven-bit device address, bit seven software flag.
// - Five bidirectional endpoints, 64-byte packets.
// - Endpoint zero shares one 64-byte buffer.
// - Endpoints one to three single or double buffers.
// - Endpoint four has single IN and OUT buffers.
// - Pull-up goes to D+ or D- by speed.
// - Bus events set flags and request interrupt.
// - Status reports endpoint and token after transfer.
// - Received toggle compared, match flagged.
// - Auto toggle flips toggle of endpoints one to three after success.
// - IN data uses endpoint transmit length.
// - Shared receive length register reports count.
// - Buffer address pairs, endpoints zero/four share.
// - Token codes OUT, SOF, IN, SETUP.
// - Receive response code selects ACK/none/NAK/STALL.
// - Flag cleared by writing zero or one.
package udec_pkg;
  localparam int EP_NUM = 5;
  localparam int MAX_PKT = 64;
  localparam int LEN_W = 7;
  localparam int DMA_W = 10;
  localparam int FULL_SPEED_BPS = 12000000;
  localparam int LOW_SPEED_BPS = 1500000;
  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_PORT = 8'hD1;
  localparam logic [7:0] IDX_EP_CTRL [EP_NUM] = '{8'hDC, 8'hD2, 8'hD4, 8'hD6, 8'hDE};
  localparam logic [7:0] IDX_EP_TLEN [EP_NUM] = '{8'hDD, 8'hD3, 8'hD5, 8'hD7, 8'hDF};
  localparam logic [7:0] IDX_DMA_L [4] = '{8'hEC, 8'hEE, 8'hE4, 8'hE6};
  localparam logic [7:0] IDX_DMA_H [4] = '{8'hED, 8'hEF, 8'hE5, 8'hE7};
  localparam logic [7:0] IDX_MOD41 = 8'hEA;
  localparam logic [7:0] IDX_MOD23 = 8'hEB;
  localparam logic [7:0] IDX_MAIN = 8'hE2;
  localparam logic [7:0] IDX_ADDR = 8'hE3;
  localparam logic [7:0] IDX_FLAG = 8'hD8;
  localparam logic [7:0] IDX_STAT = 8'hD9;
  localparam logic [7:0] IDX_RXLEN = 8'hDB;
  localparam logic [7:0] MAIN_RST = 8'h06;
  localparam logic [7:0] MAIN_MASK = 8'h7F;
  localparam int MC_SPEED = 6;
  localparam int MC_SYS_HI = 5;
  localparam int MC_SYS_LO = 4;
  localparam int MC_NAK_PAUSE = 3;
  localparam int MC_ENG_RST = 2;
  localparam int MC_CLR = 1;
  localparam int MC_DMA = 0;
  localparam logic [7:0] PORT_RST = 8'h80;
  localparam logic [7:0] PORT_WMASK = 8'h87;
  localparam int PC_PD_DIS = 7;
  localparam int PC_DP = 5;
  localparam int PC_DM = 4;
  localparam int PC_SPEED = 2;
  localparam logic [7:0] EPC_WMASK = 8'hDF;
  localparam int EC_RTOG = 7;
  localparam int EC_TTOG = 6;
  localparam int EC_AUTO = 4;
  localparam int FG_OV = 4;
  localparam int FG_SUSP = 2;
  localparam int FG_XFER = 1;
  localparam int FG_BRST = 0;
  localparam logic [7:0] FLAG_MASK = 8'h17;
  localparam logic [1:0] SYS_OFF = 2'b00;
  localparam logic [1:0] TOK_OUT = 2'b00;
  localparam logic [1:0] TOK_SOF = 2'b01;
  localparam logic [1:0] TOK_IN = 2'b10;
  localparam logic [1:0] TOK_SETUP = 2'b11;
  localparam logic [1:0] RES_ACK = 2'b00;
  localparam logic [1:0] RES_NONE = 2'b01;
  localparam logic [1:0] RES_NAK = 2'b10;
  localparam logic [1:0] RES_STALL = 2'b11;
  typedef logic [EP_NUM-1:0][7:0] udec_ep8_t;
  typedef logic [EP_NUM-1:0][LEN_W-1:0] udec_len_t;
  typedef logic [3:0][DMA_W-1:0] udec_dma_t;
  typedef struct packed {
    logic bus_rst;
    logic suspend;
    logic fifo_ov;
    logic xfer_done;
    logic is_nak;
    logic [3:0] ep;
    logic [1:0] token;
    logic rx_tog;
    logic [7:0] rx_len;
  } udec_evt_s;
  typedef struct packed {
    logic low_speed;
    logic func_en;
    logic port_en;
    logic pu_dp;
    logic pu_dm;
    logic pd_dp;
    logic pd_dm;
  } udec_phy_s;
  typedef struct packed {
    logic eng_rst;
    logic fifo_clr;
    logic nak_pause;
    logic dma_en;
    logic [6:0] dev_addr;
  } udec_ctl_s;
endpackage : udec_pkg

// ---- udec_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Register, pull-up and event tests.
module tb;
  import udec_pkg::*;
  logic core_clk, rst_n, hsel, hwrite, hrdy, hresp, usb_irq, dp_pin, dm_pin;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [15:0] ep_mode;
  logic [7:0] d, h;
  udec_evt_s evt;
  udec_phy_s phy;
  udec_ctl_s ctl;
  udec_ep8_t ep_ctrl;
  udec_len_t tx_len;
  udec_dma_t buf_addr;
  int n_fail = 0;
  int checked = 0;
  int seed = 70051;
  udec_top u_dut (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hresp(hresp),
    .hrdata(hrdata), .evt(evt), .dp_pin(dp_pin), .dm_pin(dm_pin), .phy(phy), .ctl(ctl),
    .ep_ctrl(ep_ctrl), .tx_len(tx_len), .buf_addr(buf_addr), .ep_mode(ep_mode), .usb_irq(usb_irq));
  udec_host_model u_host (.core_clk(core_clk), .evt(evt));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic req(input logic [7:0] i, input logic w, input logic [7:0] v);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {22'h0, i, 2'b00};
    do @(posedge core_clk); while (hrdy !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h0, v};
    do @(posedge core_clk); while (hrdy !== 1'b1);
    rdv = hrdata;
    repeat (2) @(posedge core_clk);
  endtask : req
  task automatic wr(input logic [7:0] i, input logic [7:0] v);
    req(i, 1'b1, v);
  endtask : wr
  task automatic rc(input logic [7:0] i, input logic [7:0] e);
    req(i, 1'b0, 8'h00);
    chk(rdv, {24'h0, e});
  endtask : rc
  task automatic close_out;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    #100000;
    n_fail++;
    close_out();
  end
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    haddr = '0;
    hwdata = '0;
    dp_pin = 1'b1;
    dm_pin = 1'b0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    rc(IDX_MAIN, 8'h06);
    chk({ctl.eng_rst, ctl.fifo_clr}, 2'b11);
    rc(IDX_PORT, 8'hA0);
    rc(IDX_ADDR, 8'h00);
    wr(IDX_EP_CTRL[1], 8'hFF);
    for (int k = 0; k < EP_NUM; k++) rc(IDX_EP_CTRL[k], 8'h00);
    wr(IDX_MAIN, 8'h00);
    rc(IDX_MAIN, 8'h00);
    chk({ctl.eng_rst, ctl.fifo_clr}, 2'b00);
    for (int k = 0; k < EP_NUM; k++) begin
      d = 8'($random(seed));
      wr(IDX_EP_CTRL[k], d);
      rc(IDX_EP_CTRL[k], d & EPC_WMASK);
      chk(ep_ctrl[k], d & EPC_WMASK);
      wr(IDX_EP_TLEN[k], d);
      rc(IDX_EP_TLEN[k], d & 8'h7F);
      chk(tx_len[k], d[6:0]);
    end
    for (int k = 0; k < 4; k++) begin
      d = 8'($random(seed));
      h = 8'($random(seed));
      wr(IDX_DMA_L[k], d);
      wr(IDX_DMA_H[k], h);
      rc(IDX_DMA_H[k], h & 8'h03);
      chk(buf_addr[k], {h[1:0], d});
    end
    wr(IDX_MOD41, d);
    wr(IDX_MOD23, h);
    chk(ep_mode, {h, d});
    wr(IDX_ADDR, d);
    rc(IDX_ADDR, d);
    chk(ctl.dev_addr, d[6:0]);
    wr(8'h00, 8'h5A);
    rc(8'h00, 8'h00);
    for (int k = 0; k < 16; k++) begin
      dp_pin <= k[1];
      dm_pin <= ~k[1];
      wr(IDX_PORT, {5'h00, k[0], 2'b01});
      wr(IDX_MAIN, {1'b0, k[3], k[2:1], 4'h0});
      rc(IDX_PORT, {2'b00, k[1], ~k[1], 1'b0, k[0], 2'b01});
      chk({phy.pd_dp, phy.pd_dm}, {~(k[2] & ~k[0]), ~(k[2] & k[0])});
      chk(phy.low_speed, k[3]);
      chk(phy.func_en, k[2:1] != SYS_OFF);
      chk({phy.pu_dp, phy.pu_dm}, {k[2] & ~k[0], k[2] & k[0]});
    end
    wr(IDX_MAIN, 8'h01);
    u_host.pulse(0, 4'h0, 2'b00, 1'b0, 8'h00);
    rc(IDX_FLAG, 8'h01);
    chk(usb_irq, 1'b1);
    wr(IDX_FLAG, 8'h01);
    rc(IDX_FLAG, 8'h00);
    u_host.pulse(1, 4'h0, 2'b00, 1'b0, 8'h00);
    u_host.pulse(3, 4'h0, 2'b00, 1'b0, 8'h00);
    rc(IDX_FLAG, 8'h14);
    wr(IDX_FLAG, 8'h10);
    rc(IDX_FLAG, 8'h04);
    wr(IDX_FLAG, 8'h00);
    rc(IDX_FLAG, 8'h00);
    chk(usb_irq, 1'b0);
    wr(IDX_EP_CTRL[1], 8'h10);
    u_host.pulse(2, 4'd1, TOK_OUT, 1'b0, 8'd37);
    rc(IDX_STAT, 8'h41);
    rc(IDX_RXLEN, 8'd37);
    u_host.pulse(2, 4'd1, TOK_IN, 1'b0, 8'd5);
    rc(IDX_STAT, 8'h21);
    chk(ep_ctrl[1], 8'hD0);
    wr(IDX_EP_CTRL[2], 8'h00);
    for (int k = 0; k < 4; k++) begin
      d = 8'($random(seed));
      u_host.pulse(2, 4'd2, k[1:0], d[0], d & 8'h3F);
      rc(IDX_STAT, {1'b0, k[0] == k[1] && !d[0], k[1:0], 4'd2});
      chk(ep_ctrl[2], 8'h00);
    end
    wr(IDX_MAIN, 8'h09);
    chk(ctl.nak_pause, 1'b1);
    wr(IDX_FLAG, 8'h02);
    chk(ctl.nak_pause, 1'b0);
    u_host.pulse(2, 4'd3, TOK_OUT, 1'b0, 8'd64);
    chk(ctl.nak_pause, 1'b1);
    wr(IDX_MAIN, 8'h01);
    chk(ctl.nak_pause, 1'b0);
    wr(IDX_MAIN, 8'h00);
    chk(usb_irq, 1'b0);
    wr(IDX_MAIN, 8'h03);
    rc(IDX_FLAG, 8'h00);
    u_host.pulse(0, 4'h0, 2'b00, 1'b0, 8'h00);
    rc(IDX_FLAG, 8'h00);
    chk(usb_irq, 1'b0);
    wr(IDX_MAIN, 8'h04);
    rc(IDX_EP_CTRL[1], 8'h00);
    rc(IDX_PORT, 8'hA0);
    chk(ctl.eng_rst, 1'b1);
    close_out();
  end
endmodule : tb
bind udec_top udec_asserts u_chk (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .evt(evt), .phy(phy),
  .ctl(ctl), .ep_ctrl(ep_ctrl), .usb_irq(usb_irq));
`default_nettype wire

// ---- udec_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module udec_top (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output var logic hreadyout,
  output var logic hresp,
  output var logic [31:0] hrdata,
  input wire udec_pkg::udec_evt_s evt,
  input wire logic dp_pin,
  input wire logic dm_pin,
  output var udec_pkg::udec_phy_s phy,
  output var udec_pkg::udec_ctl_s ctl,
  output var udec_pkg::udec_ep8_t ep_ctrl,
  output var udec_pkg::udec_len_t tx_len,
  output var udec_pkg::udec_dma_t buf_addr,
  output var logic [15:0] ep_mode,
  output var logic usb_irq
);
  import udec_pkg::*;

  // ==========================================================
  // Bus slave.
  logic ph_wr_r;
  logic ph_rd_r;
  logic [7:0] ph_idx_r;
  logic [7:0] rd_byte;
  wire logic acc = hsel & htrans[1] & hready;
  wire logic idx_ok = (haddr[31:10] == 22'h000000) & (haddr[1:0] == 2'b00);
  wire logic [7:0] wb = hwdata[7:0];

  function automatic logic wr_hit(input logic [7:0] idx);
    wr_hit = ph_wr_r & (ph_idx_r == idx);
  endfunction : wr_hit

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_wr_r <= 1'b0;
      ph_rd_r <= 1'b0;
      ph_idx_r <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
    end else begin
      ph_wr_r <= acc & hwrite & idx_ok;
      ph_rd_r <= acc & ~hwrite;
      if (acc) begin
        ph_idx_r <= idx_ok ? haddr[9:2] : 8'h00;
      end
      // Reads take one wait state so a write just ahead is seen.
      hreadyout <= ~(acc & ~hwrite);
      hresp <= 1'b0;
      if (ph_rd_r) begin
        hrdata <= {24'h000000, rd_byte};
      end
    end
  end

  // ==========================================================
  // Control registers.
  logic [7:0] main_r;
  logic [7:0] addr_r;
  logic [7:0] port_r;
  logic [7:0] flag_r;
  logic [7:0] stat_r;
  logic [7:0] rxlen_r;
  logic [15:0] mode_r;
  logic [1:0] dp_sync_r;
  logic [1:0] dm_sync_r;
  udec_ep8_t ep_r;
  udec_ep8_t ep_nxt;
  udec_len_t len_r;
  udec_dma_t dma_r;

  wire logic eng_rst = main_r[MC_ENG_RST];
  wire logic clr_all = main_r[MC_CLR];
  wire logic [1:0] sys_ctl = main_r[MC_SYS_HI:MC_SYS_LO];
  wire logic port_speed = port_r[PC_SPEED];
  wire logic done = evt.xfer_done & ~eng_rst;
  wire logic rx_tok = (evt.token == TOK_OUT) | (evt.token == TOK_SETUP);
  wire logic tx_tok = evt.token == TOK_IN;
  wire logic [2:0] ev_ep = (evt.ep < 4'd5) ? evt.ep[2:0] : 3'd0;
  wire logic ev_ep_ok = evt.ep < 4'd5;
  wire logic tog_ok = evt.rx_tog == ep_r[ev_ep][EC_RTOG];
  // Written out here: a function that reads module state does not wake a continuous assignment.
  wire logic flag_wr = ph_wr_r & (ph_idx_r == IDX_FLAG);
  wire logic [7:0] flag_clr = flag_wr ? ((wb == 8'h00) ? 8'hFF : wb) : 8'h00;
  wire logic [7:0] flag_set = {3'b000, evt.fifo_ov & ~eng_rst, 1'b0, evt.suspend & ~eng_rst,
                               done, evt.bus_rst & ~eng_rst};

  always_comb begin
    ep_nxt = ep_r;
    for (int i = 0; i < EP_NUM; i++) begin
      if (wr_hit(IDX_EP_CTRL[i])) begin
        ep_nxt[i] = wb & EPC_WMASK;
      end
      // Endpoints one to three flip their own toggle when enabled.
      if (done & ev_ep_ok & (ev_ep == 3'(i)) & (i >= 1) & (i <= 3) & ep_r[i][EC_AUTO]) begin
        if (rx_tok & tog_ok) begin
          ep_nxt[i][EC_RTOG] = ~ep_nxt[i][EC_RTOG];
        end
        if (tx_tok) begin
          ep_nxt[i][EC_TTOG] = ~ep_nxt[i][EC_TTOG];
        end
      end
    end
  end

  // Main control and address live outside the engine reset.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      main_r <= MAIN_RST;
      addr_r <= 8'h00;
      mode_r <= 16'h0000;
      dma_r <= '0;
      len_r <= '0;
      dp_sync_r <= 2'b00;
      dm_sync_r <= 2'b00;
    end else begin
      dp_sync_r <= {dp_sync_r[0], dp_pin};
      dm_sync_r <= {dm_sync_r[0], dm_pin};
      if (wr_hit(IDX_MAIN)) begin
        main_r <= wb & MAIN_MASK;
      end
      if (wr_hit(IDX_ADDR)) begin
        addr_r <= wb;
      end
      if (wr_hit(IDX_MOD41)) begin
        mode_r[7:0] <= wb;
      end
      if (wr_hit(IDX_MOD23)) begin
        mode_r[15:8] <= wb;
      end
      for (int i = 0; i < 4; i++) begin
        if (wr_hit(IDX_DMA_L[i])) begin
          dma_r[i][7:0] <= wb;
        end
        if (wr_hit(IDX_DMA_H[i])) begin
          dma_r[i][DMA_W-1:8] <= wb[DMA_W-9:0];
        end
      end
      for (int i = 0; i < EP_NUM; i++) begin
        if (wr_hit(IDX_EP_TLEN[i])) begin
          len_r[i] <= wb[LEN_W-1:0];
        end
      end
    end
  end

  // Registers under the engine reset.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_r <= PORT_RST;
      ep_r <= '0;
      flag_r <= 8'h00;
      stat_r <= 8'h00;
      rxlen_r <= 8'h00;
    end else if (eng_rst) begin
      port_r <= PORT_RST;
      ep_r <= '0;
      flag_r <= 8'h00;
      stat_r <= 8'h00;
      rxlen_r <= 8'h00;
    end else begin
      if (wr_hit(IDX_PORT)) begin
        port_r <= wb & PORT_WMASK;
      end
      ep_r <= ep_nxt;
      if (clr_all) begin
        flag_r <= 8'h00;
      end else begin
        // A new event wins over a clear in the same cycle.
        flag_r <= ((flag_r & ~flag_clr) | flag_set) & FLAG_MASK;
      end
      if (done) begin
        stat_r <= {evt.is_nak, rx_tok & tog_ok, evt.token, evt.ep};
        if (rx_tok) begin
          rxlen_r <= evt.rx_len;
        end
      end
    end
  end

  // ==========================================================
  // Read mux.
  always_comb begin
    rd_byte = 8'h00;
    if (ph_idx_r == IDX_MAIN) begin
      rd_byte = main_r;
    end
    if (ph_idx_r == IDX_ADDR) begin
      rd_byte = addr_r;
    end
    if (ph_idx_r == IDX_PORT) begin
      rd_byte = port_r;
      rd_byte[PC_DP] = dp_sync_r[1];
      rd_byte[PC_DM] = dm_sync_r[1];
    end
    if (ph_idx_r == IDX_FLAG) begin
      rd_byte = flag_r;
    end
    if (ph_idx_r == IDX_STAT) begin
      rd_byte = stat_r;
    end
    if (ph_idx_r == IDX_RXLEN) begin
      rd_byte = rxlen_r;
    end
    if (ph_idx_r == IDX_MOD41) begin
      rd_byte = mode_r[7:0];
    end
    if (ph_idx_r == IDX_MOD23) begin
      rd_byte = mode_r[15:8];
    end
    for (int i = 0; i < EP_NUM; i++) begin
      if (ph_idx_r == IDX_EP_CTRL[i]) begin
        rd_byte = ep_r[i];
      end
      if (ph_idx_r == IDX_EP_TLEN[i]) begin
        rd_byte = {1'b0, len_r[i]};
      end
    end
    for (int i = 0; i < 4; i++) begin
      if (ph_idx_r == IDX_DMA_L[i]) begin
        rd_byte = dma_r[i][7:0];
      end
      if (ph_idx_r == IDX_DMA_H[i]) begin
        rd_byte = {6'b000000, dma_r[i][DMA_W-1:8]};
      end
    end
  end

  // ==========================================================
  // Registered outputs toward the engine and transceiver.
  wire logic pu_on = sys_ctl[1];
  wire logic pu_dp = pu_on & ~port_speed;
  wire logic pu_dm = pu_on & port_speed;
  wire logic pd_on = ~port_r[PC_PD_DIS];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phy <= '0;
      ctl <= '0;
      ep_ctrl <= '0;
      tx_len <= '0;
      buf_addr <= '0;
      ep_mode <= 16'h0000;
      usb_irq <= 1'b0;
    end else begin
      phy.low_speed <= main_r[MC_SPEED];
      phy.func_en <= sys_ctl != SYS_OFF;
      phy.port_en <= port_r[0];
      phy.pu_dp <= pu_dp;
      phy.pu_dm <= pu_dm;
      phy.pd_dp <= pd_on & ~pu_dp;
      phy.pd_dm <= pd_on & ~pu_dm;
      ctl.eng_rst <= eng_rst;
      ctl.fifo_clr <= clr_all;
      ctl.nak_pause <= main_r[MC_NAK_PAUSE] & flag_r[FG_XFER];
      ctl.dma_en <= main_r[MC_DMA];
      ctl.dev_addr <= addr_r[6:0];
      ep_ctrl <= ep_r;
      tx_len <= len_r;
      buf_addr <= dma_r;
      ep_mode <= mode_r;
      usb_irq <= main_r[MC_DMA] & (flag_r != 8'h00);
    end
  end
endmodule : udec_top
`default_nettype wire
